// >>> x25_packet_header_parser.sv
// Packet-level header parser with AHB-Lite registers and an input octet FIFO
// What this block does
// (RULE1) Octet one bits 7..5: 001 modulo 8, 010 modulo 128; bit 8 flag.
// (RULE2) Window limit reported: 8 outstanding for modulo 8, 128 for modulo 128.
// (RULE3) Octet one bits 1..4 give channel group 0..15, absent in restart.
// (RULE4) Octet two gives channel number 0..255, absent in restart packets.
// (RULE5) Type 17 clear confirm, 23 interrupt, 27 interrupt confirm.
// (RULE6) Type 0B call request, 0F call accepted, 13 clear request.
// (RULE7) Flow control on low five bits: 01 RR, 05 RNR, 09 reject.
// (RULE8) Reset 1B and 1F, restart FB and FF, each request with confirm.
// (RULE9) Octet four low nibble is called address length in digits.
// (RULE10) Octet four high nibble is calling address length in digits.
// (RULE11) Called digits start at octet five, one per nibble, exact count.
// (RULE12) Calling digits follow; odd total pads last low nibble with zeros.
// (RULE13) Octet after address: facility length bits 1..6, at most 62.
// (RULE14) Facilities are code and parameter pairs, at most 62 octets.
// (RULE15) Call request user data at most 16 octets after facilities.
// (RULE16) Without facilities, one configurable user data limit for all channels.
// (RULE17) Octets arrive whole, bit 1 in the least significant position.
// (RULE18) Bit 1 zero means data; unmatched type codes raise a type error.
// (RULE19) Field overrun of the packet or over a maximum raises length error.
`include "x25_cfg.svh"

module x25_packet_header_parser #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Octet stream from the link layer
  input wire logic octet_valid,
  output logic octet_ready,
  input wire logic [7:0] octet_data,
  input wire logic octet_last
);
  // ==========================================================
  // Declarations
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic pop;
  logic [7:0] oct;
  logic last;
  logic enable, next_enable;
  logic [7:0] user_limit, next_user_limit;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  x25_pkg::state_t state, next_state;
  x25_pkg::kind_t kind, next_kind;
  logic flag8, next_flag8;
  logic mod128, next_mod128;
  logic chan_present, next_chan_present;
  logic [3:0] group, next_group;
  logic [7:0] channel, next_channel;
  logic [7:0] type_octet, next_type_octet;
  logic [3:0] called_len, next_called_len;
  logic [3:0] calling_len, next_calling_len;
  logic [4:0] addr_left, next_addr_left;
  logic [5:0] fac_len, next_fac_len;
  logic [5:0] fac_left, next_fac_left;
  logic [7:0] data_cnt, next_data_cnt;
  logic err_len, next_err_len;
  logic err_type, next_err_type;
  logic err_fmt, next_err_fmt;
  logic done, next_done;
  logic [15:0] pkt_count, next_pkt_count;
  logic [4:0] digits;
  logic [7:0] data_limit;
  logic addr_phase;
  logic clear_done;

  // ==========================================================
  // Input FIFO; a disabled parser stalls it so back-pressure reaches the link
  octet_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(octet_valid),
    .in_ready(octet_ready),
    .in_data({octet_last, octet_data}),
    .out_valid(fifo_valid),
    .out_ready(enable),
    .out_data(fifo_data)
  );

  assign pop = fifo_valid && enable;
  assign oct = fifo_data[7:0]; // RULE17
  assign last = fifo_data[8];

  // ==========================================================
  // Type classification
  function automatic x25_pkg::kind_t classify(input logic [7:0] code);
    if (!code[0]) begin
      classify = x25_pkg::kind_data; // RULE18
    end else if (code == `TYPE_RESTART_REQ) begin
      classify = x25_pkg::kind_restart_request; // RULE8
    end else if (code == `TYPE_RESTART_CONF) begin
      classify = x25_pkg::kind_restart_confirm; // RULE8
    end else if (code == `TYPE_RESET_REQ) begin
      classify = x25_pkg::reset_request_type; // RULE8
    end else if (code == `TYPE_RESET_CONF) begin
      classify = x25_pkg::reset_confirm_type; // RULE8
    end else if (code == `TYPE_CALL_REQ) begin
      classify = x25_pkg::kind_call_request; // RULE6
    end else if (code == `TYPE_CALL_ACC) begin
      classify = x25_pkg::kind_call_accept; // RULE6
    end else if (code == `TYPE_CLEAR_REQ) begin
      classify = x25_pkg::clear_request_type; // RULE6
    end else if (code == `TYPE_CLEAR_CONF) begin
      classify = x25_pkg::clear_confirm_type; // RULE5
    end else if (code == `TYPE_INT) begin
      classify = x25_pkg::kind_interrupt; // RULE5
    end else if (code == `TYPE_INT_CONF) begin
      classify = x25_pkg::kind_interrupt_confirm; // RULE5
    end else if (code[4:0] == `FC_RR) begin
      classify = x25_pkg::kind_receive_ready; // RULE7
    end else if (code[4:0] == `FC_RNR) begin
      classify = x25_pkg::kind_receive_not_ready; // RULE7
    end else if (code[4:0] == `FC_REJ) begin
      classify = x25_pkg::kind_reject; // RULE7
    end else begin
      classify = x25_pkg::kind_unknown; // RULE18
    end
  endfunction

  // Total address digit count, called plus calling
  assign digits = {1'b0, called_len} + {1'b0, calling_len};
  // A facility field caps call data at 16; otherwise the shared limit applies
  assign data_limit = (fac_len != 6'h00) ? `CALL_DATA_MAX : user_limit; // RULE15 RULE16

  // ==========================================================
  // Parser next state
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_flag8 = flag8;
    next_mod128 = mod128;
    next_chan_present = chan_present;
    next_group = group;
    next_channel = channel;
    next_type_octet = type_octet;
    next_called_len = called_len;
    next_calling_len = calling_len;
    next_addr_left = addr_left;
    next_fac_len = fac_len;
    next_fac_left = fac_left;
    next_data_cnt = data_cnt;
    next_err_len = err_len;
    next_err_type = err_type;
    next_err_fmt = err_fmt;
    next_pkt_count = pkt_count;
    if (pop) begin
      unique case (state)
        x25_pkg::st_gfi: begin
          next_err_len = last; // RULE19
          next_err_type = 1'b0;
          next_err_fmt = (oct[6:4] != `GFI_MOD8) && (oct[6:4] != `GFI_MOD128); // RULE1
          next_flag8 = oct[7]; // RULE1
          next_mod128 = (oct[6:4] == `GFI_MOD128); // RULE1
          next_group = oct[3:0]; // RULE3
          next_chan_present = 1'b1;
          next_kind = x25_pkg::kind_none;
          next_called_len = 4'h0;
          next_calling_len = 4'h0;
          next_fac_len = 6'h00;
          next_data_cnt = 8'h00;
          next_state = x25_pkg::st_chan;
        end
        x25_pkg::st_chan: begin
          next_channel = oct; // RULE4
          next_err_len = err_len | last; // RULE19
          next_state = x25_pkg::st_type;
        end
        x25_pkg::st_type: begin
          next_type_octet = oct;
          next_kind = classify(oct); // RULE5 RULE6 RULE7 RULE8
          next_err_type = (classify(oct) == x25_pkg::kind_unknown); // RULE18
          // Restart packets carry no channel identification
          next_chan_present = !((oct == `TYPE_RESTART_REQ) || (oct == `TYPE_RESTART_CONF)); // RULE3 RULE4
          if (oct == `TYPE_CALL_REQ) begin
            next_err_len = err_len | last; // RULE19
            next_state = x25_pkg::st_alen;
          end else begin
            next_state = x25_pkg::st_skip;
          end
        end
        x25_pkg::st_alen: begin
          next_called_len = oct[3:0]; // RULE9
          next_calling_len = oct[7:4]; // RULE10
          next_addr_left = 5'((({1'b0, oct[3:0]} + {1'b0, oct[7:4]}) + 5'h01) >> 1); // RULE11 RULE12
          next_err_len = err_len | last; // RULE19
          next_state = ((oct[3:0] == 4'h0) && (oct[7:4] == 4'h0)) ? x25_pkg::st_flen
                                                                   : x25_pkg::st_addr;
        end
        x25_pkg::st_addr: begin
          next_addr_left = addr_left - 5'h01; // RULE11
          next_err_len = err_len | last; // RULE19
          if (addr_left == 5'h01) begin
            // Odd digit count leaves the low nibble as filler that must be zero
            next_err_fmt = err_fmt | (digits[0] && (oct[3:0] != 4'h0)); // RULE12
            next_state = x25_pkg::st_flen;
          end
        end
        x25_pkg::st_flen: begin
          next_fac_len = oct[5:0]; // RULE13
          next_fac_left = oct[5:0];
          next_err_fmt = err_fmt | (oct[7:6] != 2'h0);
          next_err_len = err_len | (oct[5:0] > `FAC_MAX) // RULE13 RULE19
                         | (last && (oct[5:0] != 6'h00)); // RULE19
          next_state = (oct[5:0] == 6'h00) ? x25_pkg::st_data : x25_pkg::st_fac;
        end
        x25_pkg::st_fac: begin
          next_fac_left = fac_left - 6'h01; // RULE14
          next_err_len = err_len | (last && (fac_left != 6'h01)); // RULE19
          if (fac_left == 6'h01) begin
            // Facilities come in code/parameter pairs
            next_err_fmt = err_fmt | fac_len[0]; // RULE14
            next_state = x25_pkg::st_data;
          end
        end
        x25_pkg::st_data: begin
          next_data_cnt = data_cnt + 8'h01;
          next_err_len = err_len | (data_cnt >= data_limit); // RULE15 RULE16 RULE19
        end
        x25_pkg::st_skip: begin
          next_state = x25_pkg::st_skip;
        end
      endcase
      if (last) begin
        next_state = x25_pkg::st_gfi;
        next_pkt_count = pkt_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= x25_pkg::st_gfi;
      kind <= x25_pkg::kind_none;
      flag8 <= 1'b0;
      mod128 <= 1'b0;
      chan_present <= 1'b0;
      group <= 4'h0;
      channel <= 8'h00;
      type_octet <= 8'h00;
      called_len <= 4'h0;
      calling_len <= 4'h0;
      addr_left <= 5'h00;
      fac_len <= 6'h00;
      fac_left <= 6'h00;
      data_cnt <= 8'h00;
      err_len <= 1'b0;
      err_type <= 1'b0;
      err_fmt <= 1'b0;
      pkt_count <= 16'h0000;
    end else begin
      state <= next_state;
      kind <= next_kind;
      flag8 <= next_flag8;
      mod128 <= next_mod128;
      chan_present <= next_chan_present;
      group <= next_group;
      channel <= next_channel;
      type_octet <= next_type_octet;
      called_len <= next_called_len;
      calling_len <= next_calling_len;
      addr_left <= next_addr_left;
      fac_len <= next_fac_len;
      fac_left <= next_fac_left;
      data_cnt <= next_data_cnt;
      err_len <= next_err_len;
      err_type <= next_err_type;
      err_fmt <= next_err_fmt;
      pkt_count <= next_pkt_count;
    end
  end

  // ==========================================================
  // Register read image
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      `REG_CTRL: w[`CTRL_ENABLE] = enable;
      `REG_STATUS: begin
        w[`ST_DONE] = done;
        w[`ST_ERR_LEN] = err_len;
        w[`ST_ERR_TYPE] = err_type;
        w[`ST_ERR_FMT] = err_fmt;
        w[`ST_MOD128] = mod128;
        w[`ST_FLAG8] = flag8;
        w[`ST_CHAN_PRESENT] = chan_present;
        w[`ST_BUSY] = (state != x25_pkg::st_gfi);
        w[`ST_WIN_LSB +: 8] = mod128 ? `WIN_MOD128 : `WIN_MOD8; // RULE2
      end
      `REG_HEADER: w = {8'h00, 4'(kind), type_octet, channel, group};
      `REG_LENGTHS: w = {data_cnt, 2'h0, fac_len, 8'h00, calling_len, called_len};
      `REG_LIMIT: w[7:0] = user_limit;
      `REG_COUNT: w[15:0] = pkt_count;
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction

  // ==========================================================
  // AHB-Lite slave: zero wait states, read data captured in the address phase
  assign addr_phase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign clear_done = wr_pend && (wr_addr == `REG_STATUS) && hwdata[`ST_DONE];

  always_comb begin
    next_wr_pend = addr_phase && hwrite;
    next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
    next_hrdata = (addr_phase && !hwrite) ? read_word(haddr[7:0]) : hrdata;
    next_enable = enable;
    next_user_limit = user_limit;
    if (wr_pend && (wr_addr == `REG_CTRL)) begin
      next_enable = hwdata[`CTRL_ENABLE];
    end
    if (wr_pend && (wr_addr == `REG_LIMIT)) begin
      next_user_limit = hwdata[7:0]; // RULE16
    end
    // A packet ending in the clearing cycle keeps its done flag
    next_done = (done && !clear_done) || (pop && last);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      enable <= 1'b0;
      user_limit <= `USER_LIMIT_RST;
      done <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      enable <= next_enable;
      user_limit <= next_user_limit;
      done <= next_done;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_pop_in(x25_pkg::state_t st);
    pop && (state == st);
  endsequence

  property p_gfi_mod;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_gfi) ##0 (oct[6:4] == `GFI_MOD128) |=> mod128 && !err_fmt;
  endproperty
  a_gfi_mod: assert property (p_gfi_mod) else $error("modulo 128 not decoded"); // RULE1

  property p_window;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_gfi) ##0 (oct[6:4] == `GFI_MOD8)
      |=> !mod128 ##1 (!mod128 || $past(pop));
  endproperty
  a_window: assert property (p_window) else $error("modulo 8 window lost"); // RULE2

  property p_group;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_gfi) |=> (group == $past(oct[3:0])) && (state != x25_pkg::st_gfi
                                    || $past(last));
  endproperty
  a_group: assert property (p_group) else $error("group number not captured"); // RULE3

  property p_channel;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_type) ##0 (oct == `TYPE_RESTART_REQ)
      |=> !chan_present && (channel == $past(channel));
  endproperty
  a_channel: assert property (p_channel) else $error("restart channel marked present"); // RULE4

  property p_interrupt;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_type) ##0 (oct == `TYPE_INT) |=> (kind == x25_pkg::kind_interrupt);
  endproperty
  a_interrupt: assert property (p_interrupt) else $error("interrupt type missed"); // RULE5

  property p_call;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_type) ##0 (oct == `TYPE_CALL_REQ) && !last
      |=> (state == x25_pkg::st_alen) && (kind == x25_pkg::kind_call_request);
  endproperty
  a_call: assert property (p_call) else $error("call request not parsed"); // RULE6

  property p_flow;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_type) ##0 (oct[4:0] == `FC_REJ)
      |=> (kind == x25_pkg::kind_reject) && !err_type;
  endproperty
  a_flow: assert property (p_flow) else $error("reject type missed"); // RULE7

  property p_unknown;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_type) ##0 (oct == 8'h03) |=> err_type;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown type not flagged"); // RULE18

  property p_fac_max;
    @(posedge hclk) disable iff (!hresetn)
      s_pop_in(x25_pkg::st_flen) ##0 (oct[5:0] > `FAC_MAX) |=> err_len;
  endproperty
  a_fac_max: assert property (p_fac_max) else $error("facility length over limit"); // RULE13

  property p_done;
    @(posedge hclk) disable iff (!hresetn)
      pop && last |=> done && (state == x25_pkg::st_gfi);
  endproperty
  a_done: assert property (p_done) else $error("packet end not reported"); // RULE19
endmodule

// >>> x25_cfg.svh
// Constants for the packet-level header parser: codes, limits, register map
`ifndef X25_CFG_SVH
`define X25_CFG_SVH

// ==========================================================
// Format identifier
`define GFI_MOD8 3'h1
`define GFI_MOD128 3'h2
`define WIN_MOD8 8'h08
`define WIN_MOD128 8'h80

// ==========================================================
// Packet type codes, octet three
`define TYPE_CALL_REQ 8'h0B
`define TYPE_CALL_ACC 8'h0F
`define TYPE_CLEAR_REQ 8'h13
`define TYPE_CLEAR_CONF 8'h17
`define TYPE_INT 8'h23
`define TYPE_INT_CONF 8'h27
`define TYPE_RESET_REQ 8'h1B
`define TYPE_RESET_CONF 8'h1F
`define TYPE_RESTART_REQ 8'hFB
`define TYPE_RESTART_CONF 8'hFF
`define FC_RR 5'h01
`define FC_RNR 5'h05
`define FC_REJ 5'h09

// ==========================================================
// Field limits
`define FAC_MAX 6'h3E
`define CALL_DATA_MAX 8'h10
`define USER_LIMIT_RST 8'h80

// ==========================================================
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_HEADER 8'h08
`define REG_LENGTHS 8'h0C
`define REG_LIMIT 8'h10
`define REG_COUNT 8'h14

// ==========================================================
// Field positions
`define CTRL_ENABLE 0
`define ST_DONE 0
`define ST_ERR_LEN 1
`define ST_ERR_TYPE 2
`define ST_ERR_FMT 3
`define ST_MOD128 4
`define ST_FLAG8 5
`define ST_CHAN_PRESENT 6
`define ST_BUSY 7
`define ST_WIN_LSB 8

`endif

// >>> x25_pkg.sv
// Types shared by the packet-level header parser
package x25_pkg;

  // ==========================================================
  // Parser states
  typedef enum logic [3:0] {
    st_gfi = 4'h0,
    st_chan = 4'h1,
    st_type = 4'h2,
    st_alen = 4'h3,
    st_addr = 4'h4,
    st_flen = 4'h5,
    st_fac = 4'h6,
    st_data = 4'h7,
    st_skip = 4'h8
  } state_t;

  // ==========================================================
  // Packet kinds
  typedef enum logic [3:0] {
    kind_none = 4'h0,
    kind_data = 4'h1,
    kind_call_request = 4'h2,
    kind_call_accept = 4'h3,
    clear_request_type = 4'h4,
    clear_confirm_type = 4'h5,
    kind_interrupt = 4'h6,
    kind_interrupt_confirm = 4'h7,
    kind_receive_ready = 4'h8,
    kind_receive_not_ready = 4'h9,
    kind_reject = 4'hA,
    reset_request_type = 4'hB,
    reset_confirm_type = 4'hC,
    kind_restart_request = 4'hD,
    kind_restart_confirm = 4'hE,
    kind_unknown = 4'hF
  } kind_t;

endpackage

// >>> octet_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module octet_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // ==========================================================
  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; only pointers say what is valid
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// >>> x25_link_peer.sv
// Link-layer peer model that hands whole octets to the parser
module x25_link_peer (
  // Clock
  input wire logic hclk,
  // Octet stream
  output logic octet_valid,
  input wire logic octet_ready,
  output logic [7:0] octet_data,
  output logic octet_last
);
  timeunit 1ns;
  timeprecision 1ns;
  bit timed_out = 1'b0;
  initial begin
    octet_valid = 1'b0;
    octet_data = 8'h00;
    octet_last = 1'b0;
  end
  // ==========================================================
  // Octet driver: held until taken, optional idle gap first
  task send(input logic [7:0] d, input logic l, input int gap);
    int n;
    if (gap > 0) begin
      idle();
    end
    repeat (gap) @(posedge hclk);
    octet_valid <= 1'b1;
    octet_data <= d;
    octet_last <= l;
    n = 0;
    @(posedge hclk);
    while (octet_ready !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    if (n == 500) begin
      timed_out = 1'b1;
    end
  endtask
  // Released lines show the inverse so stale values never look fresh
  task idle();
    octet_valid <= 1'b0;
    octet_data <= ~octet_data;
    octet_last <= ~octet_last;
  endtask
endmodule

// >>> x25_packet_header_parser_tb.sv
// Self-checking bench for the packet header parser
`include "x25_cfg.svh"
module x25_packet_header_parser_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, octet_valid, octet_ready, octet_last;
  logic [31:0] hrdata;
  logic [7:0] octet_data;
  int fail_count = 0;
  int cmp_count = 0;
  always #25 hclk = ~hclk;
  // ==========================================================
  // Instances, FIFO shortened so that it fills quickly
  x25_packet_header_parser #(.FIFO_DEPTH(4)) u_x25_packet_header_parser (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .octet_valid(octet_valid), .octet_ready(octet_ready),
    .octet_data(octet_data), .octet_last(octet_last));
  x25_link_peer u_x25_link_peer (.hclk(hclk), .octet_valid(octet_valid),
    .octet_ready(octet_ready), .octet_data(octet_data), .octet_last(octet_last));
  // ==========================================================
  // Reporting and bus tasks
  task complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task hold_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n == 100) begin
        fail_count++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hold_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hold_ready();
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task rd(input string what, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(what, e & m, r & m);
  endtask
  // Polls for done, compares status, then clears done
  task wait_done(input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0;
    while (r[0] !== 1'b1) begin
      n++;
      if (n == 200) begin
        fail_count++;
        complete_run();
      end
      ahb(1'b0, `REG_STATUS, 32'h0, r);
    end
    chk("status", e & m, r & m);
    wr(`REG_STATUS, 32'h1);
  endtask
  task pkt(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      u_x25_link_peer.send(q[i], i == q.size() - 1, gap);
    end
    u_x25_link_peer.idle();
  endtask
  // ==========================================================
  // Scenarios
  task t_reset();
    rd("ctrl", `REG_CTRL, 32'h0, 32'hFFFFFFFF);
    chk("hresp", 32'h0, {31'h0, hresp});
    rd("limit", `REG_LIMIT, 32'h80, 32'hFFFFFFFF);
    wr(8'h40, 32'hDEADBEEF);
    rd("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF);
  endtask
  // Octets queue while parsing is off, until the FIFO refuses
  task t_call();
    logic [7:0] h[4] = '{8'h15, 8'h2A, 8'h0B, 8'h23};
    foreach (h[i]) begin
      u_x25_link_peer.send(h[i], 1'b0, 0);
    end
    u_x25_link_peer.idle();
    #1 chk("ready full", 32'h0, {31'h0, octet_ready});
    @(posedge hclk);
    wr(`REG_CTRL, 32'h1);
    pkt('{8'h12, 8'h34, 8'h50, 8'h02, 8'h42, 8'h01, 8'hAA}, 2);
    wait_done(32'h841, 32'hFFFF);
    rd("header", `REG_HEADER, 32'h0020B2A5, 32'hFFFFFFFF);
    rd("lengths", `REG_LENGTHS, 32'h01020023, 32'hFFFFFFFF);
    rd("status clear", `REG_STATUS, 32'h0, 32'h1);
    chk("ready drained", 32'h1, {31'h0, octet_ready});
  endtask
  task t_types();
    logic [7:0] ty[14] = '{8'h0F, 8'h13, 8'h17, 8'h23, 8'h27, 8'hE1, 8'h05, 8'h09, 8'h1B,
      8'h1F, 8'hFB, 8'hFF, 8'h00, 8'h03};
    logic [3:0] kd[14] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC,
      4'hD, 4'hE, 4'h1, 4'hF};
    logic [31:0] e;
    foreach (ty[i]) begin
      pkt('{8'h27, 8'h81, ty[i]}, i % 3);
      e = 32'h8011 | (ty[i][7:3] == 5'h1F ? 32'h0 : 32'h40) | (kd[i] == 4'hF ? 32'h4 : 32'h0);
      wait_done(e, 32'hFFFF);
      rd("header", `REG_HEADER, {8'h00, kd[i], ty[i], 8'h81, 4'h7}, 32'hFFFFFFFF);
    end
  endtask
  task t_errors();
    pkt('{8'hB0, 8'h00, 8'h0F}, 0);
    wait_done(32'h69, 32'h6F);
    pkt('{8'h10, 8'h01}, 0);
    wait_done(32'h3, 32'hF);
    pkt('{8'h10, 8'h03, 8'h0B, 8'h00, 8'h3F}, 0);
    wait_done(32'h3, 32'h3);
    wr(`REG_LIMIT, 32'h1);
    pkt('{8'h10, 8'h02, 8'h0B, 8'h11, 8'h12, 8'h00, 8'hAA, 8'hBB}, 1);
    wait_done(32'h43, 32'h4F);
    rd("lengths", `REG_LENGTHS, 32'h02000011, 32'hFFFFFFFF);
    pkt('{8'h10, 8'h02, 8'h0B, 8'h11, 8'h12, 8'h00, 8'hAA}, 0);
    wait_done(32'h41, 32'h4F);
    pkt('{8'h10, 8'h02, 8'h0B, 8'h01, 8'h15, 8'h00}, 0);
    wait_done(32'h49, 32'h4F);
    pkt('{8'h10, 8'h02, 8'h0B, 8'h00, 8'h01, 8'hAA}, 0);
    wait_done(32'h49, 32'h4F);
    rd("count", `REG_COUNT, 32'h16, 32'hFFFF);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_call();
    t_types();
    t_errors();
    chk("peer stall", 32'h0, {31'h0, u_x25_link_peer.timed_out});
    complete_run();
  end
endmodule
